// ---- sat_axis_model.sv ----
// Far-side model: axis events and general input pins
module sat_axis_model
  import sat_pkg::*;
(
  input  wire logic   clk,
  output sat_axis_ev_t axisEv,
  output logic [7:0]   pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] evQ = 12'h000;
  logic [7:0]  pinQ = 8'h00;
  assign axisEv = sat_axis_ev_t'(evQ);
  assign pins = pinQ;
  // One-cycle pulse, bit 7 timer down to bit 0 split pulse
  task automatic pulse(input int b);
    @(posedge clk);
    evQ[b] <= 1'b1;
    @(posedge clk);
    evQ[b] <= 1'b0;
  endtask
  task automatic cmp(input logic [3:0] v);
    @(posedge clk);
    evQ[11:8] <= v;
  endtask
  task automatic setPin(input int i, input logic v);
    @(posedge clk);
    pinQ[i] <= v;
  endtask
endmodule

// ---- sat_pkg.sv ----
// Package: constants, register map and carrier types for the trigger select block
// Operation
// - Four independent synchronous-action sets per axis, each fires alone.
// - Code 1 fires set m when compare result m turns true.
// - Compare already true at enable fires at once, then needs false-true again.
// - Compare object and condition are set by a mode command, e.g. greater-equal.
// - Code 2 fires when internal timer expires; timer loaded and started by commands.
// - Codes 3 to 6 fire on drive start, constant entry, constant exit, drive end.
// - Code 7 fires when split-pulse output starts.
// - Code 8 fires when the final split pulse has completed.
// - Code 9 fires on each split pulse reaching its valid level.
// - Code A fires set m on rising edge of input pin m.
// - Input already high at enable does not fire on rising detection.
// - Code B fires set m on falling edge of input pin m.
// - Input already low at enable does not fire on falling detection.
// - Codes C to F qualify pin k edge with level of pin k+4.
// - Fire goes straight to the action logic with no host step.
package sat_pkg;

  localparam int SETS       = 4;
  localparam int CODE_W     = 4;
  localparam int ADDR_W     = 8;

  localparam logic [CODE_W-1:0] FC_NOP      = 4'h0;
  localparam logic [CODE_W-1:0] FC_CMP      = 4'h1;
  localparam logic [CODE_W-1:0] FC_TIMER    = 4'h2;
  localparam logic [CODE_W-1:0] FC_DRV_ST   = 4'h3;
  localparam logic [CODE_W-1:0] FC_CONST_IN = 4'h4;
  localparam logic [CODE_W-1:0] FC_CONST_OUT= 4'h5;
  localparam logic [CODE_W-1:0] FC_DRV_END  = 4'h6;
  localparam logic [CODE_W-1:0] FC_SPL_ST   = 4'h7;
  localparam logic [CODE_W-1:0] FC_SPL_END  = 4'h8;
  localparam logic [CODE_W-1:0] FC_SPL_OUT  = 4'h9;
  localparam logic [CODE_W-1:0] FC_PIN_RISE = 4'hA;
  localparam logic [CODE_W-1:0] FC_PIN_FALL = 4'hB;
  localparam logic [CODE_W-1:0] FC_LO_RISE  = 4'hC;
  localparam logic [CODE_W-1:0] FC_HI_RISE  = 4'hD;
  localparam logic [CODE_W-1:0] FC_LO_FALL  = 4'hE;
  localparam logic [CODE_W-1:0] FC_HI_FALL  = 4'hF;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] REG_FACTOR  = 8'h00;
  localparam logic [ADDR_W-1:0] REG_ENABLE  = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STATUS  = 8'h08;
  localparam logic [ADDR_W-1:0] REG_MASK    = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_PINS    = 8'h10;

  // Field layout: factor code of set m at bits [4m+3:4m]
  localparam int FACTOR_W   = SETS * CODE_W;
  localparam logic [FACTOR_W-1:0] FACTOR_RST = 16'h0000;
  localparam logic [SETS-1:0]     SET_RST    = 4'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Axis-side events, all one-cycle pulses except cmpTrue
  typedef struct packed {
    logic [SETS-1:0] cmpTrue;
    logic            timerUp;
    logic            drvStart;
    logic            constIn;
    logic            constOut;
    logic            drvEnd;
    logic            splStart;
    logic            splEnd;
    logic            splPulse;
  } sat_axis_ev_t;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic              awvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [ADDR_W-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } sat_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } sat_axi_rsp_t;

endpackage

// ---- sat_trigger_select.sv ----
// Module: four-set activation factor detection with AXI4-Lite registers
module sat_trigger_select
  import sat_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         clkEn,
  input  wire sat_axi_req_t axiReq,
  output sat_axi_rsp_t      axiRsp,
  input  wire sat_axis_ev_t axisEv,
  input  wire logic [7:0]   generalInputPin,
  output logic [SETS-1:0]   fireStrobe,
  output logic              irq
);

  typedef struct packed {
    logic [7:0]          pinMeta;
    logic [7:0]          pinSync;
    logic [7:0]          pinPrev;
    logic [SETS-1:0]     cmpPrev;
    logic [FACTOR_W-1:0] factor;
    logic [SETS-1:0]     enable;
    logic [SETS-1:0]     armed;
    logic [SETS-1:0]     fire;
    logic [SETS-1:0]     status;
    logic [SETS-1:0]     mask;
    logic                irq;
    logic [ADDR_W-1:0]   awAddr;
    logic                awHave;
    logic [31:0]         wData;
    logic [3:0]          wStrb;
    logic                wHave;
    sat_axi_rsp_t        rsp;
  } sat_state_t;

  sat_state_t st_q;
  sat_state_t st_d;

  function automatic logic [CODE_W-1:0] codeOf(input logic [FACTOR_W-1:0] f, input int m);
    codeOf = f[m*CODE_W +: CODE_W];
  endfunction

  // Read data of one register word
  function automatic logic [31:0] regRead(input sat_state_t s, input logic [ADDR_W-1:0] a);
    regRead = 32'h0000_0000;
    case (a)
      REG_FACTOR: begin
        regRead = {16'h0000, s.factor};
      end
      REG_ENABLE: begin
        regRead = {28'h0000000, s.enable};
      end
      REG_STATUS: begin
        regRead = {28'h0000000, s.status};
      end
      REG_MASK: begin
        regRead = {28'h0000000, s.mask};
      end
      REG_PINS: begin
        regRead = {24'h000000, s.pinSync};
      end
      default: begin
        regRead = 32'h0000_0000;
      end
    endcase
  endfunction

  function automatic logic knownAddr(input logic [ADDR_W-1:0] a);
    knownAddr = (a == REG_FACTOR) || (a == REG_ENABLE) || (a == REG_STATUS)
             || (a == REG_MASK) || (a == REG_PINS);
  endfunction

  // Rising edge of one synchronised pin
  function automatic logic pinRise(
    input logic [7:0] sync,
    input logic [7:0] prev,
    input int         m
  );
    pinRise = sync[m] && !prev[m];
  endfunction

  // Falling edge of one synchronised pin
  function automatic logic pinFall(
    input logic [7:0] sync,
    input logic [7:0] prev,
    input int         m
  );
    pinFall = !sync[m] && prev[m];
  endfunction

  // Activation condition of one set for its factor code
  function automatic logic factorHit(
    input logic [CODE_W-1:0] code,
    input sat_axis_ev_t      ev,
    input int                m,
    input logic              cmpNew,
    input logic              rise,
    input logic              fall,
    input logic              qual
  );
    factorHit = 1'b0;
    unique case (code)
      FC_NOP: begin
        factorHit = 1'b0;
      end
      FC_CMP: begin
        factorHit = ev.cmpTrue[m] && cmpNew;
      end
      FC_TIMER: begin
        factorHit = ev.timerUp;
      end
      FC_DRV_ST: begin
        factorHit = ev.drvStart;
      end
      FC_CONST_IN: begin
        factorHit = ev.constIn;
      end
      FC_CONST_OUT: begin
        factorHit = ev.constOut;
      end
      FC_DRV_END: begin
        factorHit = ev.drvEnd;
      end
      FC_SPL_ST: begin
        factorHit = ev.splStart;
      end
      FC_SPL_END: begin
        factorHit = ev.splEnd;
      end
      FC_SPL_OUT: begin
        factorHit = ev.splPulse;
      end
      FC_PIN_RISE: begin
        factorHit = rise;
      end
      FC_PIN_FALL: begin
        factorHit = fall;
      end
      FC_LO_RISE: begin
        factorHit = rise && !qual;
      end
      FC_HI_RISE: begin
        factorHit = rise && qual;
      end
      FC_LO_FALL: begin
        factorHit = fall && !qual;
      end
      FC_HI_FALL: begin
        factorHit = fall && qual;
      end
    endcase
  endfunction

  // Sticky flags; an event in the clearing cycle wins
  function automatic logic [SETS-1:0] stickyNext(
    input logic [SETS-1:0] flags,
    input logic [SETS-1:0] clr,
    input logic [SETS-1:0] evt
  );
    stickyNext = (flags & ~clr) | evt;
  endfunction

  // Previous pin sample reloaded for newly enabled sets
  function automatic logic [3:0] seedPrev(
    input logic [3:0] prev,
    input logic [3:0] sync,
    input logic [3:0] newEn
  );
    seedPrev = (prev & ~newEn) | (sync & newEn);
  endfunction

  // Low nibble of a write, zero when byte 0 is not strobed
  function automatic logic [3:0] lowNibble(
    input logic [31:0] data,
    input logic [3:0]  strb
  );
    lowNibble = strb[0] ? data[3:0] : 4'h0;
  endfunction

  // Write response for one address
  function automatic sat_axi_rsp_t writeAnswer(
    input sat_axi_rsp_t      base,
    input logic [ADDR_W-1:0] a
  );
    writeAnswer        = base;
    writeAnswer.bvalid = 1'b1;
    writeAnswer.bresp  = knownAddr(a) ? RESP_OKAY : RESP_SLVERR;
  endfunction

  // Read answer with data and response code
  function automatic sat_axi_rsp_t readAnswer(
    input sat_axi_rsp_t      base,
    input sat_state_t        s,
    input logic [ADDR_W-1:0] a
  );
    readAnswer         = base;
    readAnswer.arready = 1'b1;
    readAnswer.rvalid  = 1'b1;
    readAnswer.rdata   = regRead(s, a);
    readAnswer.rresp   = knownAddr(a) ? RESP_OKAY : RESP_SLVERR;
  endfunction

  always_comb begin
    logic [SETS-1:0] hit;
    logic [SETS-1:0] newEn;
    logic [SETS-1:0] w1c;
    logic            doWrite;
    logic [3:0]      lo;
    logic            rise;
    logic            fall;
    logic            qual;
    hit     = '0;
    newEn   = '0;
    w1c     = '0;
    doWrite = 1'b0;
    lo      = 4'h0;
    rise    = 1'b0;
    fall    = 1'b0;
    qual    = 1'b0;
    st_d    = st_q;

    // Two-stage pin synchroniser
    st_d.pinMeta = generalInputPin;
    st_d.pinSync = st_q.pinMeta;
    st_d.pinPrev = st_q.pinSync;
    st_d.cmpPrev = axisEv.cmpTrue;

    // Factor decode per set
    for (int m = 0; m < SETS; m++) begin
      rise = pinRise(st_q.pinSync, st_q.pinPrev, m);
      fall = pinFall(st_q.pinSync, st_q.pinPrev, m);
      qual = st_q.pinSync[m+4];
      hit[m] = factorHit(codeOf(st_q.factor, m), axisEv, m,
                         st_q.armed[m] || !st_q.cmpPrev[m], rise, fall, qual);
      // Disabled sets never fire
      hit[m] = hit[m] && st_q.enable[m];
    end

    // Armed flag marks first cycle after enable; edges then see seeded prev
    st_d.armed = '0;
    st_d.fire  = hit;

    // AXI write channel capture
    st_d.rsp.awready = 1'b0;
    st_d.rsp.wready  = 1'b0;
    if (!st_q.awHave && axiReq.awvalid && !st_q.rsp.bvalid) begin
      st_d.awHave      = 1'b1;
      st_d.awAddr      = axiReq.awaddr;
      st_d.rsp.awready = 1'b1;
    end
    if (!st_q.wHave && axiReq.wvalid && !st_q.rsp.bvalid) begin
      st_d.wHave      = 1'b1;
      st_d.wData      = axiReq.wdata;
      st_d.wStrb      = axiReq.wstrb;
      st_d.rsp.wready = 1'b1;
    end
    if (st_q.rsp.awready) begin
      st_d.rsp.awready = 1'b0;
    end
    if (st_q.rsp.wready) begin
      st_d.rsp.wready = 1'b0;
    end
    doWrite = st_q.awHave && st_q.wHave && !st_q.rsp.bvalid;
    if (doWrite) begin
      st_d.awHave     = 1'b0;
      st_d.wHave      = 1'b0;
      st_d.rsp = writeAnswer(st_d.rsp, st_q.awAddr);
      lo       = lowNibble(st_q.wData, st_q.wStrb);
      unique case (st_q.awAddr)
        REG_FACTOR: begin
          if (st_q.wStrb[0]) begin
            st_d.factor[7:0] = st_q.wData[7:0];
          end
          if (st_q.wStrb[1]) begin
            st_d.factor[15:8] = st_q.wData[15:8];
          end
        end
        REG_ENABLE: begin
          if (st_q.wStrb[0]) begin
            newEn       = lo & ~st_q.enable;
            st_d.enable = lo;
            st_d.armed  = newEn;
            st_d.pinPrev[3:0] = seedPrev(st_q.pinPrev[3:0], st_q.pinSync[3:0], newEn);
          end
        end
        REG_STATUS: w1c = lo;
        REG_MASK: begin
          if (st_q.wStrb[0]) begin
            st_d.mask = lo;
          end
        end
        default: begin
        end
      endcase
    end
    if (st_q.rsp.bvalid && axiReq.bready) begin
      st_d.rsp.bvalid = 1'b0;
    end

    // AXI read channel
    st_d.rsp.arready = 1'b0;
    if (axiReq.arvalid && !st_q.rsp.rvalid && !st_q.rsp.arready) begin
      st_d.rsp = readAnswer(st_d.rsp, st_q, axiReq.araddr);
    end
    if (st_q.rsp.rvalid && axiReq.rready) begin
      st_d.rsp.rvalid = 1'b0;
    end

    // Sticky status, set wins over clear
    st_d.status = stickyNext(st_q.status, w1c, st_q.fire);
    st_d.irq    = |(st_d.status & st_q.mask);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q.pinMeta <= 8'h00;
      st_q.pinSync <= 8'h00;
      st_q.pinPrev <= 8'h00;
      st_q.cmpPrev <= SET_RST;
      st_q.factor  <= FACTOR_RST;
      st_q.enable  <= SET_RST;
      st_q.armed   <= SET_RST;
      st_q.fire    <= SET_RST;
      st_q.status  <= SET_RST;
      st_q.mask    <= SET_RST;
      st_q.irq     <= 1'b0;
      st_q.awAddr  <= '0;
      st_q.awHave  <= 1'b0;
      st_q.wData   <= 32'h0000_0000;
      st_q.wStrb   <= 4'h0;
      st_q.wHave   <= 1'b0;
      st_q.rsp     <= '0;
    end else if (clkEn) begin
      st_q <= st_d;
    end
  end

  assign axiRsp     = st_q.rsp;
  assign fireStrobe = st_q.fire;
  assign irq        = st_q.irq;

endmodule

// ---- sat_trigger_select_properties.sv ----
// Port checks for the trigger select block
module sat_trigger_select_properties
  import sat_pkg::*;
(
  input wire logic            clk,
  input wire logic            rst_n,
  input wire logic            clkEn,
  input wire sat_axi_req_t    axiReq,
  input wire sat_axi_rsp_t    axiRsp,
  input wire sat_axis_ev_t    axisEv,
  input wire logic [7:0]      generalInputPin,
  input wire logic [SETS-1:0] fireStrobe,
  input wire logic            irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] seenQ;
  logic [3:0]  quietQ;
  logic        cause;
  // Any event, level change or register write restarts the count
  assign cause = axisEv[7:0] != 8'h00 || axiRsp.wready || !clkEn
      || {axisEv.cmpTrue, generalInputPin} != seenQ;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seenQ <= 12'h000;
      quietQ <= 4'h0;
    end else begin
      seenQ <= {axisEv.cmpTrue, generalInputPin};
      quietQ <= cause ? 4'h0 : quietQ + {3'h0, quietQ != 4'hF};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !clkEn);
  sequence wrTaken;
    axiRsp.awready && axiRsp.wready;
  endsequence
  sequence rdAsked;
    axiReq.arvalid && !axiRsp.arready && !axiRsp.rvalid;
  endsequence
  aw_single_pulse_a: assert property (axiRsp.awready |=> !axiRsp.awready)
    else $error("awready longer than one cycle");
  write_resp_after_a: assert property (wrTaken |=> axiRsp.bvalid)
    else $error("no write response after capture");
  write_resp_done_a: assert property (axiRsp.bvalid && axiReq.bready |=> !axiRsp.bvalid)
    else $error("bvalid stayed after bready");
  read_answer_a: assert property (rdAsked |=> axiRsp.arready && axiRsp.rvalid)
    else $error("read not answered next cycle");
  read_done_a: assert property (axiRsp.rvalid && axiReq.rready |=> !axiRsp.rvalid)
    else $error("rvalid stayed after rready");
  no_take_busy_a: assert property (axiRsp.bvalid |-> !axiRsp.awready && !axiRsp.wready)
    else $error("write taken while response pending");
  fire_has_cause_a: assert property (fireStrobe != 4'h0 |-> quietQ < 4'h7)
    else $error("fire with no recent cause");
  irq_has_cause_a: assert property ($rose(irq) |-> $past(fireStrobe != 4'h0)
      || $past(axiRsp.wready) || $past(axiRsp.wready, 2) || $past(axiRsp.bvalid))
    else $error("irq rose with no fire or write");
endmodule
bind sat_trigger_select sat_trigger_select_properties chk (.clk(clk), .rst_n(rst_n),
  .clkEn(clkEn), .axiReq(axiReq), .axiRsp(axiRsp), .axisEv(axisEv),
  .generalInputPin(generalInputPin), .fireStrobe(fireStrobe), .irq(irq));

// ---- sat_trigger_select_tb.sv ----
// Self-checking bench for the trigger select block
module sat_trigger_select_tb
  import sat_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         clkEn = 1'b1;
  sat_axi_req_t axiReq = '0;
  sat_axi_rsp_t axiRsp;
  sat_axis_ev_t axisEv;
  logic [7:0]   pins;
  logic [3:0]   fireStrobe;
  logic [3:0]   fireSeen = 4'h0;
  logic         irq;
  int           fireCnt = 0;
  int           mismatches = 0;
  int           checkCount = 0;
  always #2.5 clk = ~clk;
  sat_trigger_select DUT (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .axiReq(axiReq),
    .axiRsp(axiRsp), .axisEv(axisEv), .generalInputPin(pins),
    .fireStrobe(fireStrobe), .irq(irq));
  sat_axis_model axisModel (.clk(clk), .axisEv(axisEv), .pins(pins));
  always @(negedge clk) begin
    fireSeen |= fireStrobe;
    fireCnt += int'(fireStrobe != 4'h0);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    axiReq <= '{awaddr:a, awvalid:1'b1, wdata:d, wstrb:4'hF, wvalid:1'b1,
      bready:1'b1, default:'0};
    do begin
      @(posedge clk);
      if (axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiRsp.wready) axiReq.wvalid <= 1'b0;
    end while (!axiRsp.bvalid);
    axiReq.bready <= 1'b0;
    chk({30'h0, axiRsp.bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    axiReq <= '{araddr:a, arvalid:1'b1, rready:1'b1, default:'0};
    do begin
      @(posedge clk);
      if (axiRsp.arready) axiReq.arvalid <= 1'b0;
    end while (!axiRsp.rvalid);
    axiReq.rready <= 1'b0;
    chk(axiRsp.rdata, e);
    chk({30'h0, axiRsp.rresp}, {30'h0, er});
  endtask
  task automatic arm();
    fireSeen = 4'h0;
    fireCnt = 0;
  endtask
  task automatic fires(input logic [3:0] e);
    repeat (8) @(negedge clk);
    @(posedge clk);
    chk({28'h0, fireSeen}, {28'h0, e});
    chk(32'(fireCnt), {31'h0, e != 4'h0});
  endtask
  task automatic t_regs();
    for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0, RESP_OKAY);
    wr(REG_FACTOR, 32'hFFFF_A5C3, RESP_OKAY);
    rd(REG_FACTOR, 32'h0000_A5C3, RESP_OKAY);
    wr(8'h14, 32'h1, RESP_SLVERR);
    rd(8'h14, 32'h0, RESP_SLVERR);
    $display("regs test done");
  endtask
  task automatic t_events();
    wr(REG_ENABLE, 32'h1, RESP_OKAY);
    for (int c = 0; c <= 9; c++) begin
      wr(REG_FACTOR, 32'(c), RESP_OKAY);
      for (int b = 0; b < 8; b++) begin
        arm();
        axisModel.pulse(b);
        fires({3'h0, b == 9 - c});
      end
    end
    $display("events test done");
  endtask
  task automatic t_cmp();
    wr(REG_FACTOR, 32'h0000_0010, RESP_OKAY);
    axisModel.cmp(4'h2);
    arm();
    wr(REG_ENABLE, 32'h2, RESP_OKAY);
    fires(4'h2);
    arm();
    axisModel.cmp(4'h3);
    fires(4'h0);
    axisModel.cmp(4'h0);
    arm();
    axisModel.cmp(4'h2);
    fires(4'h2);
    $display("compare test done");
  endtask
  task automatic t_pins();
    logic rise;
    logic ql;
    for (int c = 10; c <= 15; c++) begin
      rise = c == 10 || c == 12 || c == 13;
      ql = c == 13 || c == 15;
      wr(REG_ENABLE, 32'h0, RESP_OKAY);
      wr(REG_FACTOR, 32'(c << 8), RESP_OKAY);
      axisModel.setPin(2, rise);
      axisModel.setPin(6, ql);
      repeat (4) @(posedge clk);
      arm();
      wr(REG_ENABLE, 32'h4, RESP_OKAY);
      axisModel.setPin(2, !rise);
      fires(4'h0);
      arm();
      axisModel.setPin(2, rise);
      fires(4'h4);
      if (c > 11) begin
        axisModel.setPin(6, !ql);
        axisModel.setPin(2, !rise);
        repeat (4) @(posedge clk);
        arm();
        axisModel.setPin(2, rise);
        fires(4'h0);
      end
    end
    $display("pins test done");
  endtask
  task automatic t_irq();
    wr(REG_FACTOR, 32'h0000_3000, RESP_OKAY);
    wr(REG_ENABLE, 32'h8, RESP_OKAY);
    axisModel.pulse(6);
    repeat (4) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rd(REG_STATUS, 32'hF, RESP_OKAY);
    wr(REG_MASK, 32'h8, RESP_OKAY);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(REG_STATUS, 32'h8, RESP_OKAY);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rd(REG_STATUS, 32'h7, RESP_OKAY);
    $display("irq test done");
  endtask
  task automatic t_freeze();
    arm();
    clkEn <= 1'b0;
    axisModel.pulse(6);
    fires(4'h0);
    clkEn <= 1'b1;
    arm();
    axisModel.pulse(6);
    fires(4'h8);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    $display("freeze test done");
  endtask
  task automatic t_reset();
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    chk({28'h0, fireStrobe}, 32'h0);
    for (int i = 0; i < 4; i++) rd(8'(4 * i), 32'h0, RESP_OKAY);
    $display("reset test done");
  endtask
  task automatic completeRun();
    $display("checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #100us;
    mismatches++;
    completeRun();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_events();
    t_cmp();
    t_pins();
    t_irq();
    t_freeze();
    t_reset();
    completeRun();
  end
endmodule
